/* File: rtl/filter_chain_consts.svh */
// constants of the cascaded servo filter chain
`ifndef FILTER_CHAIN_CONSTS_SVH
`define FILTER_CHAIN_CONSTS_SVH
`define NUM_LINKS        6
`define NUM_STAGES       4
`define NUM_FIELDS       4
`define NUM_CFG          96
`define LINK_TORQUE_FEED 0
`define LINK_TORQUE_FB   1
`define LINK_SPEED_FEED  2
`define LINK_SPEED_FB    3
`define LINK_POS_FEED    4
`define LINK_POS_FB      5
`define FLD_TYPE         2'h0
`define FLD_CUTOFF       2'h1
`define FLD_NOTCH_FREQ   2'h2
`define FLD_NOTCH_DEPTH  2'h3
`define TYPE_MAX         16'h0004
`define CUTOFF_MIN       16'h00C8
`define CUTOFF_MAX       16'h1388
`define NFREQ_MIN        16'h0003
`define NFREQ_MAX        16'h1388
`define NDEPTH_MIN       16'h0003
`define NDEPTH_MAX       16'h0032
`define RST_TYPE         16'h0000
`define RST_CUTOFF       16'h00C8
`define RST_NFREQ        16'h0064
`define RST_NDEPTH       16'h0005
`define RST_SPD_TYPE     16'h0001
`define RST_SPD_CUTOFF   16'h03E8
`define ADDR_CFG_END     12'h180
`define ADDR_STATUS      12'h180
`define ADDR_COUNT       12'h184
`define K_FULL           205887
`define K_MAX            16'h7FFF
`define FRAC_BITS        8
`define ZERO_SHIFT       2
`define DEPTH_BIAS       16'h0003
`define DEPTH_STEP       16'h0006
`endif

/* File: rtl/filter_chain_pkg.sv */
// shared types of the cascaded servo filter chain
package filter_chain_pkg;
  typedef logic signed [15:0] sample_t;
  typedef logic [15:0] setting_t;
  // filter kinds in setting order 0..4
  typedef enum logic [2:0] {FT_BYPASS, FT_LP1, FT_LP2, FT_LP2_ZERO, FT_NOTCH} filt_type_t;
endpackage

/* File: rtl/filter_stage.sv */
// one filter module: bypass, low-pass variants or notch
`include "filter_chain_consts.svh"
module filter_stage
  import filter_chain_pkg::*;
#(
  parameter int SAMPLE_RATE_HZ = 32000,
  parameter bit FORCE_BYPASS   = 1'b0
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // sample stream
  input  wire logic                       sample_tick,
  input  wire filter_chain_pkg::sample_t  x_in,
  output filter_chain_pkg::sample_t       y_out,
  output logic                            active,
  // settings
  input  wire filter_chain_pkg::setting_t set_type,
  input  wire filter_chain_pkg::setting_t set_cutoff,
  input  wire filter_chain_pkg::setting_t set_nfreq,
  input  wire filter_chain_pkg::setting_t set_ndepth
);
  import filter_chain_pkg::*;
  localparam logic [15:0] KMUL = 16'((`K_FULL * 256) / SAMPLE_RATE_HZ);
  if (SAMPLE_RATE_HZ < 10000 || SAMPLE_RATE_HZ > 1000000) begin : g_chk
    $error("filter_stage: sample rate out of range");
  end

  typedef struct packed {
    setting_t          sh_type;  // settings last turned into coefficients
    setting_t          sh_cut;
    setting_t          sh_nf;
    setting_t          sh_nd;
    filt_type_t        ftype;
    logic [15:0]       k_lp;     // q15 corner gain
    logic [15:0]       k_nt;     // q15 notch tuning gain
    logic [3:0]        dshift;   // residual at notch centre, as a shift
    logic signed [27:0] s1;      // first integrator
    logic signed [27:0] s2;      // second integrator or band-pass
  } stage_state_t;

  stage_state_t st;
  stage_state_t next_st;

  // gain from frequency, clamped to keep the integrator stable
  function automatic logic [15:0] calc_k(input setting_t f);
    logic [31:0] p;
    p = (32'(f) * 32'(KMUL)) >> 8;
    return (p > 32'(`K_MAX)) ? `K_MAX : p[15:0];
  endfunction

  // scale by a q15 gain
  function automatic logic signed [27:0] mulk(input logic signed [28:0] v, input logic [15:0] k);
    logic signed [45:0] m;
    m = 46'(v) * 46'($signed({1'b0, k}));
    return 28'(m >>> 15);
  endfunction

  // saturate back to a sample
  function automatic sample_t sat(input logic signed [28:0] v);
    logic signed [28:0] t;
    t = v >>> `FRAC_BITS;
    if (t > 29'sh7FFF) return 16'sh7FFF;
    if (t < -29'sh8000) return -16'sh8000;
    return t[15:0];
  endfunction

  logic signed [27:0] w;
  logic signed [27:0] a;
  logic signed [27:0] b;
  logic signed [28:0] hp;
  assign w = {{4{x_in[15]}}, x_in, 8'h00};

  ////////////////////////////////////////////////////////////////
  // coefficient refresh and one sample per tick
  always_comb begin
    next_st = st;
    y_out   = x_in;
    a       = '0;
    b       = '0;
    hp      = '0;
    // coefficients follow settings only on a change; state kept
    if (set_type != st.sh_type || set_cutoff != st.sh_cut ||
        set_nfreq != st.sh_nf || set_ndepth != st.sh_nd) begin
      next_st.sh_type = set_type;
      next_st.sh_cut  = set_cutoff;
      next_st.sh_nf   = set_nfreq;
      next_st.sh_nd   = set_ndepth;
      next_st.ftype   = (set_type > `TYPE_MAX) ? FT_BYPASS : filt_type_t'(set_type[2:0]);
      next_st.k_lp    = calc_k(set_cutoff);
      next_st.k_nt    = calc_k(set_nfreq);
      next_st.dshift  = 4'((set_ndepth + `DEPTH_BIAS) / `DEPTH_STEP);
    end
    if (FORCE_BYPASS) begin
      // reserved group: straight through
      next_st.s1 = '0;
      next_st.s2 = '0;
    end else begin
      case (st.ftype)
        FT_LP1: begin
          // single pole, corner from cutoff only
          a     = st.s1 + mulk(29'(w) - 29'(st.s1), st.k_lp);
          y_out = sat(29'(a));
          if (sample_tick) next_st.s1 = a;
        end
        FT_LP2, FT_LP2_ZERO: begin
          // two poles, steeper roll-off
          a = st.s1 + mulk(29'(w) - 29'(st.s1), st.k_lp);
          b = st.s2 + mulk(29'(a) - 29'(st.s2), st.k_lp);
          if (st.ftype == FT_LP2) y_out = sat(29'(b));
          else y_out = sat(29'(b) + ((29'(w) - 29'(b)) >>> `ZERO_SHIFT));
          if (sample_tick) begin
            next_st.s1 = a;
            next_st.s2 = b;
          end
        end
        FT_NOTCH: begin
          // state-variable band-pass taken away from input
          a     = st.s1 + mulk(29'(st.s2), st.k_nt);
          hp    = 29'(w) - 29'(a) - 29'(st.s2);
          b     = st.s2 + mulk(hp, st.k_nt);
          y_out = sat(29'(w) - 29'(b) + 29'(b >>> st.dshift));
          if (sample_tick) begin
            next_st.s1 = a;
            next_st.s2 = b;
          end
        end
        default: begin
          // bypass: same-period pass, state held clear
          next_st.s1 = '0;
          next_st.s2 = '0;
        end
      endcase
    end
  end

  assign active = !FORCE_BYPASS && st.ftype != FT_BYPASS;

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* File: rtl/filter_link.sv */
// one filter link: four filter modules in series
`include "filter_chain_consts.svh"
module filter_link
  import filter_chain_pkg::*;
#(
  parameter int SAMPLE_RATE_HZ = 32000,
  parameter bit FORCE_BYPASS   = 1'b0
) (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // sample stream
  input  wire logic                            sample_tick,
  input  wire filter_chain_pkg::sample_t       x_in,
  output filter_chain_pkg::sample_t            y_out,
  output logic                                 active,
  // settings, module-major then field
  input  wire filter_chain_pkg::setting_t [15:0] cfg
);
  import filter_chain_pkg::*;
  sample_t [`NUM_STAGES:0] tap;   // tap[i] feeds module i
  logic [`NUM_STAGES-1:0]  act;   // per-module active flags
  assign tap[0] = x_in;

  // each module drives the next one's input
  for (genvar i = 0; i < `NUM_STAGES; i++) begin : g_stage
    filter_stage #(
      .SAMPLE_RATE_HZ (SAMPLE_RATE_HZ),
      .FORCE_BYPASS   (FORCE_BYPASS)
    ) u_stage (
      .pclk        (pclk),
      .presetn     (presetn),
      .sample_tick (sample_tick),
      .x_in        (tap[i]),
      .y_out       (tap[i+1]),
      .active      (act[i]),
      .set_type    (cfg[i*`NUM_FIELDS + `FLD_TYPE]),
      .set_cutoff  (cfg[i*`NUM_FIELDS + `FLD_CUTOFF]),
      .set_nfreq   (cfg[i*`NUM_FIELDS + `FLD_NOTCH_FREQ]),
      .set_ndepth  (cfg[i*`NUM_FIELDS + `FLD_NOTCH_DEPTH])
    );
  end

  assign y_out  = tap[`NUM_STAGES];
  assign active = |act;
endmodule

/* File: rtl/cascaded_servo_filter_chain.sv */
// top of the cascaded servo filter chain with its apb register file
//
// Overview of operation
// - six links: torque, speed, position paths
// - four filter modules in series per link
// - position links configurable but pass unchanged
// - four settings for every filter module
// - type 0..4: bypass, lp1, lp2, lp2z, notch
// - cutoff 200..5000 hz sets low-pass corner
// - cutoff unused in bypass or notch
// - notch centre 3..5000 hz, default 100
// - notch depth 3..50 db, deeper attenuates more
// - notch settings unused in bypass, low-pass
// - low-pass rolls off; second order steeper
// - notch cuts centre, leaves far frequencies
// - speed feedback defaults to 1000 hz lp1
`include "filter_chain_consts.svh"
module cascaded_servo_filter_chain
  import filter_chain_pkg::*;
#(
  parameter int SAMPLE_RATE_HZ = 32000
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // samples from the loop datapath
  input  wire logic                      sample_tick,
  input  wire filter_chain_pkg::sample_t torque_feed_in,
  input  wire filter_chain_pkg::sample_t torque_fb_in,
  input  wire filter_chain_pkg::sample_t speed_feed_in,
  input  wire filter_chain_pkg::sample_t speed_fb_in,
  input  wire filter_chain_pkg::sample_t pos_feed_in,
  input  wire filter_chain_pkg::sample_t pos_fb_in,
  // filtered samples back to the datapath
  output logic                           sample_out_valid,
  output filter_chain_pkg::sample_t      torque_feed_out,
  output filter_chain_pkg::sample_t      torque_fb_out,
  output filter_chain_pkg::sample_t      speed_feed_out,
  output filter_chain_pkg::sample_t      speed_fb_out,
  output filter_chain_pkg::sample_t      pos_feed_out,
  output filter_chain_pkg::sample_t      pos_fb_out
);
  import filter_chain_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    setting_t [`NUM_CFG-1:0]   cfg;       // word index = link*16+module*4+field
    logic [31:0]               rdata;     // read data caught in setup
    logic [15:0]               count;     // samples processed, wraps
    sample_t [`NUM_LINKS-1:0]  dout;      // registered link outputs
    logic                      dvalid;    // pulse after each tick
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  setting_t [`NUM_CFG-1:0] cfg_init; // factory settings as a fixed value

  // factory settings; speed feedback module 0 starts as lp1
  function automatic setting_t [`NUM_CFG-1:0] cfg_reset();
    setting_t [`NUM_CFG-1:0] r;
    for (int n = 0; n < `NUM_CFG; n++) begin
      case (n % `NUM_FIELDS)
        0:       r[n] = `RST_TYPE;
        1:       r[n] = `RST_CUTOFF;
        2:       r[n] = `RST_NFREQ;
        default: r[n] = `RST_NDEPTH;
      endcase
    end
    r[`LINK_SPEED_FB*16 + `FLD_TYPE]   = `RST_SPD_TYPE;
    r[`LINK_SPEED_FB*16 + `FLD_CUTOFF] = `RST_SPD_CUTOFF;
    return r;
  endfunction

  // pull a written value into the field's legal range
  function automatic setting_t clamp(input logic [1:0] fld, input setting_t v);
    setting_t lo;
    setting_t hi;
    lo = 16'h0000;
    hi = `TYPE_MAX;
    case (fld)
      `FLD_CUTOFF: begin
        lo = `CUTOFF_MIN;
        hi = `CUTOFF_MAX;
      end
      `FLD_NOTCH_FREQ: begin
        lo = `NFREQ_MIN;
        hi = `NFREQ_MAX;
      end
      `FLD_NOTCH_DEPTH: begin
        lo = `NDEPTH_MIN;
        hi = `NDEPTH_MAX;
      end
      default: begin
        lo = 16'h0000;
        hi = `TYPE_MAX;
      end
    endcase
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  // folded at elaboration so the reset branch loads only a constant
  localparam setting_t [`NUM_CFG-1:0] CFG_INIT = cfg_reset();
  assign cfg_init = CFG_INIT;

  ////////////////////////////////////////////////////////////////
  // link array

  sample_t [`NUM_LINKS-1:0] din;    // raw inputs by link index
  sample_t [`NUM_LINKS-1:0] lout;   // combinational link results
  logic [`NUM_LINKS-1:0]    lact;   // link has a live filter

  assign din[`LINK_TORQUE_FEED] = torque_feed_in;
  assign din[`LINK_TORQUE_FB]   = torque_fb_in;
  assign din[`LINK_SPEED_FEED]  = speed_feed_in;
  assign din[`LINK_SPEED_FB]    = speed_fb_in;
  assign din[`LINK_POS_FEED]    = pos_feed_in;
  assign din[`LINK_POS_FB]      = pos_fb_in;

  // one link per signal path
  for (genvar l = 0; l < `NUM_LINKS; l++) begin : g_link
    filter_link #(
      .SAMPLE_RATE_HZ (SAMPLE_RATE_HZ),
      // position groups keep registers but never filter
      .FORCE_BYPASS   (l == `LINK_POS_FEED || l == `LINK_POS_FB)
    ) u_link (
      .pclk        (pclk),
      .presetn     (presetn),
      .sample_tick (sample_tick),
      .x_in        (din[l]),
      .y_out       (lout[l]),
      .active      (lact[l]),
      .cfg         (st.cfg[l*16 +: 16])
    );
  end

  ////////////////////////////////////////////////////////////////
  // apb decode

  logic       setup;     // first cycle of a transfer
  logic       access;    // completing cycle
  logic       in_cfg;    // address falls in the settings block
  logic [6:0] widx;      // settings word index
  logic       bad_type;  // write of an undefined filter type

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign in_cfg   = paddr < `ADDR_CFG_END;
  assign widx     = paddr[8:2];
  // type above 4 is refused rather than clamped
  assign bad_type = pwrite && in_cfg && widx[1:0] == `FLD_TYPE && pwdata[15:0] > `TYPE_MAX;

  // no wait states; errors for holes and refused writes
  assign pready  = 1'b1;
  assign pslverr = access && ((!in_cfg && paddr != `ADDR_STATUS && paddr != `ADDR_COUNT) || bad_type);

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // read data is fetched in setup so it comes from a flop
    if (setup) begin
      if (in_cfg) begin
        next_st.rdata = {16'h0000, st.cfg[widx]};
      end else if (paddr == `ADDR_STATUS) begin
        next_st.rdata = {26'h0000000, lact};
      end else if (paddr == `ADDR_COUNT) begin
        next_st.rdata = {16'h0000, st.count};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
    // write lands on the completing edge only
    if (access && pwrite && in_cfg && !bad_type) begin
      next_st.cfg[widx] = clamp(widx[1:0], pwdata[15:0]);
    end
    // capture chain outputs once per sample period
    next_st.dvalid = sample_tick;
    if (sample_tick) begin
      next_st.dout  = lout;
      next_st.count = st.count + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.cfg    <= CFG_INIT;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign prdata           = st.rdata;
  assign sample_out_valid = st.dvalid;
  assign torque_feed_out  = st.dout[`LINK_TORQUE_FEED];
  assign torque_fb_out    = st.dout[`LINK_TORQUE_FB];
  assign speed_feed_out   = st.dout[`LINK_SPEED_FEED];
  assign speed_fb_out     = st.dout[`LINK_SPEED_FB];
  assign pos_feed_out     = st.dout[`LINK_POS_FEED];
  assign pos_fb_out       = st.dout[`LINK_POS_FB];
endmodule

/* File: sim/filter_chain_properties.sv */
// concurrent checks on the filter chain top-level ports
module filter_chain_checker (
  // clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // apb slave side
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // sample stream
  input wire logic                      sample_tick,
  input wire filter_chain_pkg::sample_t pos_feed_in,
  input wire filter_chain_pkg::sample_t pos_fb_in,
  input wire logic                      sample_out_valid,
  input wire filter_chain_pkg::sample_t pos_feed_out,
  input wire filter_chain_pkg::sample_t pos_fb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import filter_chain_pkg::*;
  // one domain, so clock and reset once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // register bus
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase without pready");
  property p_err_access;
    pslverr |-> psel && penable;
  endproperty
  a_err_access: assert property (p_err_access) else $error("error outside access phase");
  property p_unmapped;
    psel && penable && paddr >= 12'h188 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  // a type above four is never stored
  property p_type_refuse;
    psel && penable && pwrite && paddr < 12'h180 && paddr[3:0] == 4'h0 && pwdata[15:0] > 16'h0004 |-> pslverr;
  endproperty
  a_type_refuse: assert property (p_type_refuse) else $error("bad type write accepted");
  property p_hi_zero;
    psel && penable |-> prdata[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read data not zero");
  // position links never count as active
  property p_pos_status;
    psel && penable && !pwrite && paddr == 12'h180 |-> prdata[5:4] == 2'b00;
  endproperty
  a_pos_status: assert property (p_pos_status) else $error("position link shown active");
  ////////////////////////////////////////////////////////////
  // sample stream
  property p_valid;
    sample_tick |=> sample_out_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("no output after tick");
  property p_valid_cause;
    sample_out_valid |-> $past(sample_tick);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("output without tick");
  property p_pos_pass;
    sample_tick |=> pos_feed_out == $past(pos_feed_in) && pos_fb_out == $past(pos_fb_in);
  endproperty
  a_pos_pass: assert property (p_pos_pass) else $error("position sample altered");
  // outputs hold between sample periods
  property p_hold;
    !sample_out_valid |-> $stable(pos_feed_out) && $stable(pos_fb_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved between ticks");
  cover property (sample_tick ##1 sample_out_valid);
  cover property (pslverr);
  cover property (psel && penable && pwrite && !pslverr);
endmodule
bind cascaded_servo_filter_chain filter_chain_checker u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sample_tick, .pos_feed_in, .pos_fb_in, .sample_out_valid, .pos_feed_out, .pos_fb_out
);

/* File: sim/loop_datapath_model.sv */
// loop datapath model: sample ticks and stimulus samples
module loop_datapath_model #(
  parameter int PERIOD = 8 // cycles per sample period
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // bench control
  input  wire logic                      run,
  input  wire filter_chain_pkg::sample_t level,
  // towards the chain
  output logic                           sample_tick,
  output filter_chain_pkg::sample_t      s_tf,
  output filter_chain_pkg::sample_t      s_tb,
  output filter_chain_pkg::sample_t      s_sf,
  output filter_chain_pkg::sample_t      s_sb,
  output filter_chain_pkg::sample_t      s_pf,
  output filter_chain_pkg::sample_t      s_pb,
  output logic [15:0]                    ticks
);
  timeunit 1ns;
  timeprecision 1ps;
  import filter_chain_pkg::*;
  int cnt; // cycles into the period
  // one tick per period while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      sample_tick <= 1'b0;
      ticks <= 16'h0000;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sample_tick <= run && cnt == PERIOD - 1;
      if (run && cnt == PERIOD - 1) begin
        ticks <= ticks + 16'h0001;
      end
    end
  end
  // data valid only in the tick cycle, a different value otherwise so a late sample shows
  assign s_tf = sample_tick ? level : ~level;
  assign s_tb = sample_tick ? level : ~level;
  assign s_sf = sample_tick ? -level : level;
  assign s_sb = sample_tick ? level : ~level;
  assign s_pf = sample_tick ? level ^ 16'h5A5A : level;
  assign s_pb = sample_tick ? ~level : level;
endmodule

/* File: sim/test_cascaded_servo_filter_chain.sv */
// self-checking bench for the cascaded servo filter chain
module test_cascaded_servo_filter_chain;
  timeunit 1ns;
  timeprecision 1ps;
  import filter_chain_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic        pready, pslverr, rd_err, tick, valid;
  logic        run = 1'b0;
  sample_t     level = 16'h0000;
  sample_t     tf_i, tb_i, sf_i, sb_i, pf_i, pb_i;
  sample_t     tf_o, tb_o, sf_o, sb_o, pf_o, pb_o;
  logic [15:0] ticks;
  int          fails = 0, cmp_count = 0, cyc = 0;
  ////////////////////////////////////////////////////////////
  always #4 pclk = ~pclk; // 125 mhz
  cascaded_servo_filter_chain uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(tick), .torque_feed_in(tf_i), .torque_fb_in(tb_i), .speed_feed_in(sf_i),
    .speed_fb_in(sb_i), .pos_feed_in(pf_i), .pos_fb_in(pb_i), .sample_out_valid(valid),
    .torque_feed_out(tf_o), .torque_fb_out(tb_o), .speed_feed_out(sf_o),
    .speed_fb_out(sb_o), .pos_feed_out(pf_o), .pos_fb_out(pb_o));
  loop_datapath_model u_loop (
    .pclk(pclk), .presetn(presetn), .run(run), .level(level), .sample_tick(tick),
    .s_tf(tf_i), .s_tb(tb_i), .s_sf(sf_i), .s_sb(sb_i), .s_pf(pf_i), .s_pb(pb_i), .ticks(ticks));
  ////////////////////////////////////////////////////////////
  // report and end the run
  task automatic stop_test;
    $display("counts: %0d mismatches in %0d comparisons", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
      fails++;
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  // one apb transfer; pready waited for, the hang guard bounds it
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
    apb(a, 1'b0, 32'h0);
    chk(rd_data, x);
    chk({31'h0, rd_err}, {31'h0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic e);
    apb(a, 1'b1, {16'h0, d});
    chk({31'h0, rd_err}, {31'h0, e});
  endtask
  // skip to the n-th next filtered sample
  task automatic smp(input int n);
    repeat (n) do @(posedge pclk); while (valid !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h0C0, 32'h1, 1'b0);
    rd(12'h0C4, 32'h3E8, 1'b0);
    rd(12'h0C8, 32'h64, 1'b0);
    rd(12'h0CC, 32'h5, 1'b0);
    rd(12'h004, 32'hC8, 1'b0);
    rd(12'h17C, 32'h5, 1'b0);
    rd(12'h180, 32'h8, 1'b0);
    rd(12'h188, 32'h0, 1'b1);
    wr(12'h188, 16'h0001, 1'b1);
    wr(12'h000, 16'h0005, 1'b1);
    rd(12'h000, 32'h0, 1'b0);
    // out-of-range settings land on the range ends
    wr(12'h004, 16'h0010, 1'b0);
    rd(12'h004, 32'hC8, 1'b0);
    wr(12'h004, 16'hFFFF, 1'b0);
    rd(12'h004, 32'h1388, 1'b0);
    wr(12'h008, 16'h0001, 1'b0);
    rd(12'h008, 32'h3, 1'b0);
    wr(12'h00C, 16'h0064, 1'b0);
    rd(12'h00C, 32'h32, 1'b0);
    wr(12'h004, 16'h00C8, 1'b0);
    for (int t = 0; t < 5; t++) begin
      wr(12'h040, t[15:0], 1'b0);
      rd(12'h040, 32'(t), 1'b0);
    end
    // robot settings: speed feedback cutoff, torque lp1 and lp2, speed feed notch, position feed type
    wr(12'h0C4, 16'h09C4, 1'b0);
    wr(12'h040, 16'h0002, 1'b0);
    wr(12'h000, 16'h0001, 1'b0);
    wr(12'h100, 16'h0002, 1'b0);
    wr(12'h080, 16'h0004, 1'b0);
    wr(12'h084, 16'h1388, 1'b0);
    wr(12'h180, 16'h0000, 1'b0);
    rd(12'h180, 32'hF, 1'b0);
    // step from zero through every link
    run <= 1'b1;
    smp(3);
    level <= 16'sd8000;
    smp(5);
    chk({16'h0, pf_o}, {16'h0, 16'h1F40 ^ 16'h5A5A});
    chk({16'h0, pb_o}, {16'h0, ~16'h1F40});
    ok(tf_o > 0 && tf_o < 16'sd8000);
    ok(tb_o < tf_o);
    ok(sb_o > 0 && sb_o < 16'sd8000);
    // leaving notch for bypass passes the second next sample exactly
    wr(12'h080, 16'h0000, 1'b0);
    level <= -16'sd1234;
    smp(2);
    chk({16'h0, sf_o}, {16'h0, 16'sd1234});
    chk({16'h0, pb_o}, {16'h0, ~(-16'sd1234)});
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(12'h184, {16'h0, ticks}, 1'b0);
    stop_test;
  end
endmodule
